// ---- logic/synth_prog_defines.svh ----
`ifndef SYNTH_PROG_DEFINES_SVH
`define SYNTH_PROG_DEFINES_SVH
// Functional notes
// - all port timing comes from master clock
// - serial clock is master clock over 128
// - one shared data line, three strobes
// - three select bits enable each strobe
// - four bytes form one 32-bit shifter
// - byte0 least significant, byte3 most significant
// - order 0 sends byte0 bit 0 first
// - polarity 1 gives positive pulses, 0 inverted
// - exact pulse count, zero means 32
// - strobe rises at programmed bit time
// - strobe falls at programmed bit time
// - idle flag high idle, low busy
// - control2 write clears flag, queues transfer unless queue full
// - status register shows lock-lost pin level
// - lock lost blocks amp enable, zeroes transmit
// - 32 data bits maximum, strobes on their own lines

// register addresses on the microcontroller port
`define SP_ADDR_WORD0 5'h03
`define SP_ADDR_WORD1 5'h04
`define SP_ADDR_WORD2 5'h05
`define SP_ADDR_WORD3 5'h06
`define SP_ADDR_CTRL0 5'h07
`define SP_ADDR_CTRL1 5'h08
`define SP_ADDR_CTRL2 5'h09
`define SP_ADDR_MSTAT 5'h10
// field positions
`define SP_SEL_MSB 7
`define SP_SEL_LSB 5
`define SP_FALL_MSB 4
`define SP_FALL_LSB 0
`define SP_ORDER_BIT 5
`define SP_RISE_MSB 4
`define SP_RISE_LSB 0
`define SP_POL_BIT 5
`define SP_COUNT_MSB 4
`define SP_COUNT_LSB 0
`define SP_STAT_IDLE_BIT 0
`define SP_STAT_LOCK_BIT 1
// reset values and timing
`define SP_REG_RESET 8'h00
`define SP_MCLK_KHZ 38880
`define SP_SCLK_DIV 128
`define SP_WORD_BITS 32
`define SP_LAST_BIT 5'h1F
`define SP_QUEUE_DEPTH 16
`endif

// ---- logic/synth_prog_pkg.sv ----
package synth_prog_pkg;
	typedef enum logic {ST_IDLE, ST_SHIFT} engine_state_t;
	typedef struct packed {
		logic [7:0] ctrl0;
		logic [7:0] ctrl1;
		logic [7:0] ctrl2;
		logic [31:0] word;
	} synth_job_t;
endpackage

// ---- logic/synth_job_fifo.sv ----
`timescale 1ns/100ps
module synth_job_fifo #(
	parameter int WIDTH = 56,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic push;
	logic pop;

	// full and empty come straight from the occupancy count
	assign in_ready = (count_reg != FULL_CNT);
	assign out_valid = (count_reg != '0);
	assign out_data = mem[rd_ptr_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// storage has no reset; only the pointers matter
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	// pointers wrap at depth, which need not be a power of two
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + 1'b1;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end
endmodule

// ---- logic/synth_sclk_timer.sv ----
`timescale 1ns/100ps
module synth_sclk_timer #(
	parameter int DIV = 128
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic run,
	output logic active_half,
	output logic bit_end
);
	localparam int CW = $clog2(DIV);
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);
	localparam logic [CW-1:0] EARLY = CW'(DIV / 2 - 1);

	logic [CW-1:0] count_reg;

	// the serial clock is registered downstream, so this window opens one count early;
	// the line then drops on the very edge at which the next data bit is launched
	assign active_half = run && (count_reg >= EARLY) && (count_reg != LAST);
	assign bit_end = run && (count_reg == LAST);

	// counter restarts from zero whenever the engine is idle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			count_reg <= '0;
		end else if (!run || count_reg == LAST) begin
			count_reg <= '0;
		end else begin
			count_reg <= count_reg + 1'b1;
		end
	end
endmodule

// ---- logic/synth_serial_programmer.sv ----
`timescale 1ns/100ps
`include "synth_prog_defines.svh"
module synth_serial_programmer #(
	parameter int DIV = `SP_SCLK_DIV,
	parameter int QUEUE_DEPTH = `SP_QUEUE_DEPTH,
	parameter int TX_W = 8
) (
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic [4:0] ADDR,
	input wire logic [7:0] WR_DATA,
	input wire logic WR_EN,
	input wire logic RD_EN,
	output logic [7:0] RD_DATA,
	output logic SYNTH_SERIAL_CLOCK,
	output logic SYNTH_SERIAL_DATA,
	output logic SYNTH_LATCH_ENABLE_0,
	output logic SYNTH_LATCH_ENABLE_1,
	output logic SYNTH_LATCH_ENABLE_2,
	output logic JOB_QUEUE_READY,
	input wire logic LOCK_LOST_INPUT,
	input wire logic TX_ENABLE,
	input wire logic [TX_W-1:0] TX_IN_PHASE_IN,
	input wire logic [TX_W-1:0] TX_QUADRATURE_IN,
	output logic POWER_AMP_ENABLE,
	output logic [TX_W-1:0] TX_IN_PHASE_OUT,
	output logic [TX_W-1:0] TX_QUADRATURE_OUT
);
	localparam int JOB_W = $bits(synth_prog_pkg::synth_job_t);

	// software-visible registers
	logic [7:0] synth_word_byte0_reg;
	logic [7:0] synth_word_byte1_reg;
	logic [7:0] synth_word_byte2_reg;
	logic [7:0] synth_word_byte3_reg;
	logic [7:0] synth_strobe_select_fall_reg;
	logic [7:0] synth_order_rise_reg;
	logic [7:0] synth_polarity_count_go_reg;
	logic programming_idle_flag_reg;
	logic [7:0] rd_data_reg;

	// job queue
	synth_prog_pkg::synth_job_t job_in;
	synth_prog_pkg::synth_job_t job_head;
	logic [JOB_W-1:0] head_bits;
	logic job_push;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic queue_ready_reg;

	// serial engine
	synth_prog_pkg::engine_state_t state_reg;
	synth_prog_pkg::synth_job_t job_reg;
	logic [31:0] shift_reg;
	logic [31:0] shift_next;
	logic [4:0] bit_idx_reg;
	logic data_reg;
	logic [2:0] le_reg;
	logic act_reg;
	logic act_next;
	logic sclk_reg;
	logic active_half;
	logic bit_end;
	logic running;
	logic cur_msb;
	logic cur_pol;
	logic [4:0] cur_rise;
	logic [4:0] cur_fall;
	logic [2:0] cur_sel;
	logic [5:0] cur_pulses;

	// transmit gating
	logic pa_en_reg;
	logic [TX_W-1:0] tx_i_reg;
	logic [TX_W-1:0] tx_q_reg;

	// first bit on the line for the chosen order
	function automatic logic first_bit(input logic [31:0] w, input logic msb);
		return msb ? w[31] : w[0];
	endfunction

	// shift toward the output end for the chosen order
	function automatic logic [31:0] shift_word(input logic [31:0] w, input logic msb);
		return msb ? {w[30:0], 1'b0} : {1'b0, w[31:1]};
	endfunction

	// a programmed count of zero stands for a full word
	function automatic logic [5:0] pulse_total(input logic [4:0] n);
		return (n == 5'h00) ? 6'h20 : {1'b0, n};
	endfunction

	// strobe level for a new bit time; fall wins if both match
	function automatic logic [2:0] strobe_step(input logic [2:0] cur, input logic [4:0] idx,
			input logic [4:0] rise, input logic [4:0] fall, input logic [2:0] sel);
		if (idx == fall) begin
			return 3'h0;
		end else if (idx == rise) begin
			return sel;
		end
		return cur;
	endfunction

	// register writes; data and control are snapshotted into the queue on go
	// byte registers
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			synth_word_byte0_reg <= `SP_REG_RESET;
			synth_word_byte1_reg <= `SP_REG_RESET;
			synth_word_byte2_reg <= `SP_REG_RESET;
			synth_word_byte3_reg <= `SP_REG_RESET;
			synth_strobe_select_fall_reg <= `SP_REG_RESET;
			synth_order_rise_reg <= `SP_REG_RESET;
			synth_polarity_count_go_reg <= `SP_REG_RESET;
		end else if (WR_EN) begin
			case (ADDR)
				`SP_ADDR_WORD0: synth_word_byte0_reg <= WR_DATA;
				`SP_ADDR_WORD1: synth_word_byte1_reg <= WR_DATA;
				`SP_ADDR_WORD2: synth_word_byte2_reg <= WR_DATA;
				`SP_ADDR_WORD3: synth_word_byte3_reg <= WR_DATA;
				`SP_ADDR_CTRL0: synth_strobe_select_fall_reg <= WR_DATA;
				`SP_ADDR_CTRL1: synth_order_rise_reg <= WR_DATA;
				`SP_ADDR_CTRL2: synth_polarity_count_go_reg <= WR_DATA;
				default: ;
			endcase
		end
	end

	// job assembly; control2 travels with the value being written
	// byte0 low, byte3 high
	assign job_in.word = {synth_word_byte3_reg, synth_word_byte2_reg,
		synth_word_byte1_reg, synth_word_byte0_reg};
	assign job_in.ctrl0 = synth_strobe_select_fall_reg;
	assign job_in.ctrl1 = synth_order_rise_reg;
	assign job_in.ctrl2 = WR_DATA;
	assign job_push = WR_EN && (ADDR == `SP_ADDR_CTRL2) && fifo_in_ready;
	assign fifo_out_ready = (state_reg == synth_prog_pkg::ST_IDLE);
	assign job_head = synth_prog_pkg::synth_job_t'(head_bits);

	// a go while the queue is full stores the register but starts nothing
	synth_job_fifo #(
		.WIDTH(JOB_W),
		.DEPTH(QUEUE_DEPTH)
	) u_queue (
		.clk(CLK),
		.rst_b(RST_B),
		.in_valid(job_push),
		.in_ready(fifo_in_ready),
		.in_data(JOB_W'(job_in)),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(head_bits)
	);

	// bit timing from the master clock
	synth_sclk_timer #(
		.DIV(DIV)
	) u_timer (
		.clk(CLK),
		.rst_b(RST_B),
		.run(running),
		.active_half(active_half),
		.bit_end(bit_end)
	);

	// fields of the job being sent
	assign running = (state_reg == synth_prog_pkg::ST_SHIFT);
	assign cur_msb = job_reg.ctrl1[`SP_ORDER_BIT];
	assign cur_rise = job_reg.ctrl1[`SP_RISE_MSB:`SP_RISE_LSB];
	assign cur_fall = job_reg.ctrl0[`SP_FALL_MSB:`SP_FALL_LSB];
	assign cur_sel = job_reg.ctrl0[`SP_SEL_MSB:`SP_SEL_LSB];
	assign cur_pulses = pulse_total(job_reg.ctrl2[`SP_COUNT_MSB:`SP_COUNT_LSB]);
	assign shift_next = shift_word(shift_reg, cur_msb);

	// engine walks all 32 bit times; pulses stop after the count
	// data and at most one strobe pulse per job, on every line that the three select bits enable
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			state_reg <= synth_prog_pkg::ST_IDLE;
			job_reg <= '0;
			shift_reg <= 32'h00000000;
			bit_idx_reg <= 5'h00;
			data_reg <= 1'b0;
			le_reg <= 3'h0;
		end else begin
			case (state_reg)
				synth_prog_pkg::ST_IDLE: begin
					le_reg <= 3'h0;
					if (fifo_out_valid) begin
						job_reg <= job_head;
						shift_reg <= job_head.word;
						bit_idx_reg <= 5'h00;
						data_reg <= first_bit(job_head.word, job_head.ctrl1[`SP_ORDER_BIT]);
						le_reg <= strobe_step(3'h0, 5'h00,
							job_head.ctrl1[`SP_RISE_MSB:`SP_RISE_LSB],
							job_head.ctrl0[`SP_FALL_MSB:`SP_FALL_LSB],
							job_head.ctrl0[`SP_SEL_MSB:`SP_SEL_LSB]);
						state_reg <= synth_prog_pkg::ST_SHIFT;
					end
				end
				synth_prog_pkg::ST_SHIFT: begin
					if (bit_end) begin
						if (bit_idx_reg == `SP_LAST_BIT) begin
							le_reg <= 3'h0;
							state_reg <= synth_prog_pkg::ST_IDLE;
						end else begin
							bit_idx_reg <= bit_idx_reg + 5'h01;
							shift_reg <= shift_next;
							data_reg <= first_bit(shift_next, cur_msb);
							le_reg <= strobe_step(le_reg, bit_idx_reg + 5'h01,
								cur_rise, cur_fall, cur_sel);
						end
					end
				end
				default: state_reg <= synth_prog_pkg::ST_IDLE;
			endcase
		end
	end

	// idle level follows the programmed polarity even between jobs
	assign cur_pol = running ? job_reg.ctrl2[`SP_POL_BIT] :
		synth_polarity_count_go_reg[`SP_POL_BIT];
	// pulses only during the first count bit times
	assign act_next = active_half && ({1'b0, bit_idx_reg} < cur_pulses);

	// output level is active level matched against polarity
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			act_reg <= 1'b0;
			sclk_reg <= 1'b1;
		end else begin
			act_reg <= act_next;
			sclk_reg <= (act_next == cur_pol);
		end
	end

	// idle means engine free and nothing queued
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			programming_idle_flag_reg <= 1'b1;
			queue_ready_reg <= 1'b0;
		end else begin
			programming_idle_flag_reg <= !running && !fifo_out_valid && !job_push;
			queue_ready_reg <= fifo_in_ready;
		end
	end

	// read port; unmapped addresses read zero
	// lock pin seen in status
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			rd_data_reg <= 8'h00;
		end else if (RD_EN) begin
			case (ADDR)
				`SP_ADDR_WORD0: rd_data_reg <= synth_word_byte0_reg;
				`SP_ADDR_WORD1: rd_data_reg <= synth_word_byte1_reg;
				`SP_ADDR_WORD2: rd_data_reg <= synth_word_byte2_reg;
				`SP_ADDR_WORD3: rd_data_reg <= synth_word_byte3_reg;
				`SP_ADDR_CTRL0: rd_data_reg <= synth_strobe_select_fall_reg;
				`SP_ADDR_CTRL1: rd_data_reg <= synth_order_rise_reg;
				`SP_ADDR_CTRL2: rd_data_reg <= synth_polarity_count_go_reg;
				`SP_ADDR_MSTAT: rd_data_reg <= {6'h00, LOCK_LOST_INPUT, programming_idle_flag_reg};
				default: rd_data_reg <= 8'h00;
			endcase
		end else begin
			rd_data_reg <= 8'h00;
		end
	end

	// an unlocked synthesizer would put the carrier off channel
	// gate amp and baseband
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			pa_en_reg <= 1'b0;
			tx_i_reg <= '0;
			tx_q_reg <= '0;
		end else begin
			pa_en_reg <= TX_ENABLE && !LOCK_LOST_INPUT;
			tx_i_reg <= LOCK_LOST_INPUT ? '0 : TX_IN_PHASE_IN;
			tx_q_reg <= LOCK_LOST_INPUT ? '0 : TX_QUADRATURE_IN;
		end
	end

	// shared clock and data, three strobes
	assign SYNTH_SERIAL_CLOCK = sclk_reg;
	assign SYNTH_SERIAL_DATA = data_reg;
	assign SYNTH_LATCH_ENABLE_0 = le_reg[0];
	assign SYNTH_LATCH_ENABLE_1 = le_reg[1];
	assign SYNTH_LATCH_ENABLE_2 = le_reg[2];
	assign JOB_QUEUE_READY = queue_ready_reg;
	assign RD_DATA = rd_data_reg;
	assign POWER_AMP_ENABLE = pa_en_reg;
	assign TX_IN_PHASE_OUT = tx_i_reg;
	assign TX_QUADRATURE_OUT = tx_q_reg;

	// helper counters for the checks below
	logic [6:0] high_len_reg;
	logic [5:0] pulse_seen_reg;
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			high_len_reg <= 7'h00;
			pulse_seen_reg <= 6'h00;
		end else begin
			high_len_reg <= act_reg ? high_len_reg + 7'h01 : 7'h00;
			if (!running) begin
				pulse_seen_reg <= 6'h00;
			end else if (act_next && !act_reg) begin
				pulse_seen_reg <= pulse_seen_reg + 6'h01;
			end
		end
	end

	a_sclk_half_period: assert property (@(posedge CLK) disable iff (!RST_B)
		(act_reg && !act_next) |-> high_len_reg == 7'(DIV / 2 - 1))
		else $error("serial clock high phase has wrong length");
	a_pulse_total: assert property (@(posedge CLK) disable iff (!RST_B)
		(running && bit_end && bit_idx_reg == 5'h1F) |-> pulse_seen_reg == cur_pulses)
		else $error("wrong number of serial clock pulses");
	a_strobe_rise_time: assert property (@(posedge CLK) disable iff (!RST_B)
		(le_reg != $past(le_reg) && le_reg != 3'h0) |-> bit_idx_reg == cur_rise)
		else $error("strobe rose at wrong bit time");
	a_strobe_fall_time: assert property (@(posedge CLK) disable iff (!RST_B)
		($past(le_reg) != 3'h0 && le_reg == 3'h0 && running) |-> bit_idx_reg == cur_fall)
		else $error("strobe fell at wrong bit time");
	a_strobe_select_mask: assert property (@(posedge CLK) disable iff (!RST_B)
		running |-> (le_reg & ~cur_sel) == 3'h0)
		else $error("unselected strobe driven");
	a_strobe_idle_low: assert property (@(posedge CLK) disable iff (!RST_B)
		(!running && $past(!running)) |-> le_reg == 3'h0)
		else $error("strobe active while idle");
	a_data_off_edge: assert property (@(posedge CLK) disable iff (!RST_B)
		(running && $changed(data_reg)) |-> !act_reg)
		else $error("data changed during active clock phase");
	a_go_clears_idle: assert property (@(posedge CLK) disable iff (!RST_B)
		job_push |=> !programming_idle_flag_reg ##1 !programming_idle_flag_reg)
		else $error("idle flag not cleared by go");
	a_lsb_first_start: assert property (@(posedge CLK) disable iff (!RST_B)
		(!running && fifo_out_valid && !job_head.ctrl1[5]) |=> data_reg == job_reg.word[0])
		else $error("first bit not byte0 bit 0");
	a_lock_status: assert property (@(posedge CLK) disable iff (!RST_B)
		(RD_EN && ADDR == 5'h10) |=> RD_DATA[1] == $past(LOCK_LOST_INPUT))
		else $error("status lock bit does not follow pin");
	a_lock_gates_tx: assert property (@(posedge CLK) disable iff (!RST_B)
		LOCK_LOST_INPUT |=> !POWER_AMP_ENABLE && TX_IN_PHASE_OUT == '0
			&& TX_QUADRATURE_OUT == '0)
		else $error("transmit not gated while lock lost");
endmodule

// ---- sim/synth_chip_model.sv ----
`timescale 1ns/100ps
// far-side synthesizer chips: sample data on the leading clock edge, log strobe edges
module synth_chip_model #(
	parameter int DIV = 16
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic pol,
	input wire logic clear,
	input wire logic collect,
	input wire logic sclk,
	input wire logic sdata,
	input wire logic [2:0] le,
	output logic report_valid,
	output logic [79:0] report
);
	logic act;
	logic act_d;
	logic sdata_d;
	logic bad;
	logic [2:0] le_d;
	logic [31:0] bits;
	logic [5:0] npulse;
	logic [5:0] r_at [3];
	logic [5:0] f_at [3];
	int gap;
	int hi;
	// active level follows the polarity the chips are wired for
	assign act = (sclk == pol);
	// pulse timing, data hold and capture
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			act_d <= 1'h0;
			sdata_d <= 1'h0;
			le_d <= 3'h0;
			report_valid <= 1'h0;
			report <= 80'h0;
			gap <= 1000;
			hi <= 0;
			bad <= 1'h0;
			bits <= 32'h0;
			npulse <= 6'h00;
			r_at <= '{3{6'h3F}};
			f_at <= '{3{6'h3F}};
		end else begin
			act_d <= act;
			sdata_d <= sdata;
			le_d <= le;
			report_valid <= collect;
			report <= {bad, 5'h00, npulse, bits, r_at[0], r_at[1], r_at[2], f_at[0], f_at[1],
				f_at[2]};
			gap <= gap + 1;
			hi <= act ? hi + 1 : 0;
			// a clear hides the idle-level shift when the polarity changes
			if (clear || collect) begin
				bad <= 1'h0;
				bits <= 32'h0;
				npulse <= 6'h00;
				gap <= 1000;
				// a strobe edge inside the cleared window still lands before any pulse
				for (int i = 0; i < 3; i++) begin
					r_at[i] <= (le[i] && !le_d[i]) ? 6'h00 : 6'h3F;
					f_at[i] <= (!le[i] && le_d[i]) ? 6'h00 : 6'h3F;
				end
			end else begin
				if (act && !act_d) begin
					bits[npulse[4:0]] <= sdata;
					npulse <= npulse + 6'h01;
					gap <= 1;
					if (gap != DIV && gap < 2 * DIV) bad <= 1'h1;
				end
				if (!act && act_d && hi != DIV / 2) bad <= 1'h1;
				if (act && act_d && sdata != sdata_d) bad <= 1'h1;
				for (int i = 0; i < 3; i++) begin
					if (le[i] && !le_d[i] && r_at[i] == 6'h3F) r_at[i] <= npulse;
					if (!le[i] && le_d[i] && f_at[i] == 6'h3F) f_at[i] <= npulse;
				end
			end
		end
	end
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/100ps
module testbench;
	localparam int DIV = 16;
	logic CLK, RST_B, WR_EN, RD_EN, LOCK_LOST_INPUT, TX_ENABLE, POWER_AMP_ENABLE;
	logic [4:0] ADDR;
	logic [7:0] WR_DATA, RD_DATA, TX_IN_PHASE_IN, TX_QUADRATURE_IN;
	logic [7:0] TX_IN_PHASE_OUT, TX_QUADRATURE_OUT;
	logic SYNTH_SERIAL_CLOCK, SYNTH_SERIAL_DATA, JOB_QUEUE_READY;
	logic SYNTH_LATCH_ENABLE_0, SYNTH_LATCH_ENABLE_1, SYNTH_LATCH_ENABLE_2;
	logic model_pol, model_clear, model_collect, report_valid, rd_pend;
	logic [79:0] report;
	logic [79:0] notes [$];
	int n_errors = 0;
	int samples_checked = 0;
	int cycles = 0;

	synth_serial_programmer #(.DIV(DIV)) dut_u (.CLK(CLK), .RST_B(RST_B), .ADDR(ADDR),
		.WR_DATA(WR_DATA), .WR_EN(WR_EN), .RD_EN(RD_EN), .RD_DATA(RD_DATA),
		.SYNTH_SERIAL_CLOCK(SYNTH_SERIAL_CLOCK), .SYNTH_SERIAL_DATA(SYNTH_SERIAL_DATA),
		.SYNTH_LATCH_ENABLE_0(SYNTH_LATCH_ENABLE_0), .SYNTH_LATCH_ENABLE_1(SYNTH_LATCH_ENABLE_1),
		.SYNTH_LATCH_ENABLE_2(SYNTH_LATCH_ENABLE_2), .JOB_QUEUE_READY(JOB_QUEUE_READY),
		.LOCK_LOST_INPUT(LOCK_LOST_INPUT), .TX_ENABLE(TX_ENABLE),
		.TX_IN_PHASE_IN(TX_IN_PHASE_IN), .TX_QUADRATURE_IN(TX_QUADRATURE_IN),
		.POWER_AMP_ENABLE(POWER_AMP_ENABLE), .TX_IN_PHASE_OUT(TX_IN_PHASE_OUT),
		.TX_QUADRATURE_OUT(TX_QUADRATURE_OUT));
	synth_chip_model #(.DIV(DIV)) chip_u (.clk(CLK), .rst_b(RST_B), .pol(model_pol),
		.clear(model_clear), .collect(model_collect), .sclk(SYNTH_SERIAL_CLOCK),
		.sdata(SYNTH_SERIAL_DATA),
		.le({SYNTH_LATCH_ENABLE_2, SYNTH_LATCH_ENABLE_1, SYNTH_LATCH_ENABLE_0}),
		.report_valid(report_valid), .report(report));

	initial begin
		CLK = 1'h0;
		forever #4 CLK = ~CLK;
	end

	task automatic check(input logic [79:0] seen, input logic [79:0] exp, input string msg);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	task automatic give_verdict;
		$display("comparisons %0d, mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic end_test(input string name);
		$display("test finished: %s", name);
	endtask

	// requests are held from one falling edge to the next, so exactly one edge takes them
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		RD_EN = 1'h0;
		ADDR = a;
		WR_DATA = d;
		WR_EN = 1'h1;
		@(negedge CLK);
	endtask

	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		notes.push_back({72'h0, e});
		WR_EN = 1'h0;
		ADDR = a;
		RD_EN = 1'h1;
		@(negedge CLK);
	endtask

	task automatic bus_idle;
		WR_EN = 1'h0;
		RD_EN = 1'h0;
		@(negedge CLK);
	endtask

	// expected chip-side view of one frame: bits, pulses, strobe edges in pulses seen
	function automatic logic [79:0] expect_frame(input logic [31:0] w, input logic [7:0] c0,
		input logic [7:0] c1, input logic [7:0] c2);
		logic [31:0] b;
		logic [5:0] n;
		logic [5:0] ra [3];
		logic [5:0] fa [3];
		logic [2:0] st;
		logic [2:0] nx;
		b = 32'h0;
		ra = '{3{6'h3F}};
		fa = '{3{6'h3F}};
		st = 3'h0;
		n = (c2[4:0] == 5'h00) ? 6'h20 : {1'h0, c2[4:0]};
		for (int k = 0; k < 32; k++) begin
			// order bit picks byte0 bit 0 or byte3 bit 7 first
			if (k < n) b[k] = c1[5] ? w[31 - k] : w[k];
			// fall wins over rise at the same bit time
			nx = (k == c0[4:0]) ? 3'h0 : ((k == c1[4:0]) ? c0[7:5] : st);
			for (int i = 0; i < 3; i++) begin
				if (nx[i] && !st[i] && ra[i] == 6'h3F) ra[i] = (k < n) ? 6'(k) : n;
				if (!nx[i] && st[i] && fa[i] == 6'h3F) fa[i] = (k < n) ? 6'(k) : n;
			end
			st = nx;
		end
		for (int i = 0; i < 3; i++) begin
			if (st[i] && fa[i] == 6'h3F) fa[i] = n;
		end
		return {1'h0, 5'h00, n, b, ra[0], ra[1], ra[2], fa[0], fa[1], fa[2]};
	endfunction

	// each job is written at once; the idle flag is only expected high after the fixed 32 * DIV + 4 cycle wait
	task automatic do_job(input logic [31:0] w, input logic [7:0] c0, input logic [7:0] c1,
		input logic [7:0] c2);
		wr(5'h03, w[7:0]);
		wr(5'h04, w[15:8]);
		wr(5'h05, w[23:16]);
		wr(5'h06, w[31:24]);
		wr(5'h07, c0);
		wr(5'h08, c1);
		wr(5'h09, c2);
		// clear spans the two edges at which the idle level may flip with polarity
		model_pol = c2[5];
		model_clear = 1'h1;
		rd(5'h10, 8'h00);
		bus_idle();
		model_clear = 1'h0;
		repeat (32 * DIV + 4) @(negedge CLK);
		rd(5'h10, 8'h01);
		rd(5'h09, c2);
		bus_idle();
		notes.push_back(expect_frame(w, c0, c1, c2));
		model_collect = 1'h1;
		@(negedge CLK);
		model_collect = 1'h0;
		@(negedge CLK);
	endtask

	// results are matched against the oldest note as they appear
	always @(posedge CLK) rd_pend <= RST_B && RD_EN;
	always @(negedge CLK) begin
		if (rd_pend || report_valid) begin
			if (notes.size() == 0) begin
				n_errors++;
				$display("MISMATCH at %0t: result without a pending note", $time);
			end else if (rd_pend) begin
				check({72'h0, RD_DATA}, notes.pop_front(), "register read");
			end else begin
				check(report, notes.pop_front(), "frame seen by chips");
			end
		end
	end

	// the ceiling sits well above the roughly 12500 cycles the tests need
	always @(posedge CLK) begin
		cycles++;
		if (cycles == 40000) begin
			n_errors++;
			$display("MISMATCH at %0t: run did not finish", $time);
			give_verdict();
		end
	end

	initial begin
		logic [7:0] d;
		RST_B = 1'h0;
		WR_EN = 1'h0;
		RD_EN = 1'h0;
		ADDR = 5'h00;
		WR_DATA = 8'h00;
		LOCK_LOST_INPUT = 1'h0;
		TX_ENABLE = 1'h0;
		TX_IN_PHASE_IN = 8'h00;
		TX_QUADRATURE_IN = 8'h00;
		model_pol = 1'h0;
		model_clear = 1'h0;
		model_collect = 1'h0;
		void'($urandom(32'h9c1b));
		repeat (8) @(negedge CLK);
		RST_B = 1'h1;
		@(negedge CLK);
		for (int a = 3; a <= 9; a++) rd(5'(a), 8'h00);
		rd(5'h10, 8'h01);
		rd(5'h1F, 8'h00);
		bus_idle();
		end_test("reset values");
		for (int a = 3; a <= 8; a++) begin
			d = 8'($urandom);
			wr(5'(a), d);
			rd(5'(a), d);
		end
		wr(5'h1F, 8'hA5);
		rd(5'h1F, 8'h00);
		bus_idle();
		end_test("register access");
		// 18-bit payload justified to the msb end for msb-first order
		do_job(32'h41990000, 8'h52, 8'h31, 8'h32);
		end_test("worked example");
		// every job carries at least one pulse; count zero gives 32
		for (int k = 0; k < 6; k++) begin
			do_job($urandom, 8'($urandom), {2'h0, k[1], 5'($urandom)},
				{2'h0, k[0], (k == 0) ? 5'h00 : 5'($urandom)});
		end
		end_test("random jobs");
		check({79'h0, JOB_QUEUE_READY}, {79'h0, 1'h1}, "queue ready");
		model_pol = 1'h1;
		model_clear = 1'h1;
		@(negedge CLK);
		model_clear = 1'h0;
		for (int a = 3; a <= 6; a++) wr(5'(a), 8'hFF);
		wr(5'h07, 8'h00);
		wr(5'h08, 8'h00);
		for (int k = 0; k < 18; k++) wr(5'h09, 8'h21);
		rd(5'h10, 8'h00);
		bus_idle();
		check({79'h0, JOB_QUEUE_READY}, 80'h0, "queue full");
		repeat (17 * (32 * DIV + 1) + 8) @(negedge CLK);
		rd(5'h10, 8'h01);
		bus_idle();
		notes.push_back({1'h0, 5'h00, 6'h11, 32'h0001FFFF, {6{6'h3F}}});
		model_collect = 1'h1;
		@(negedge CLK);
		model_collect = 1'h0;
		@(negedge CLK);
		end_test("job queue");
		for (int k = 0; k < 8; k++) begin
			LOCK_LOST_INPUT = k[0];
			TX_ENABLE = k[1];
			TX_IN_PHASE_IN = 8'($urandom);
			TX_QUADRATURE_IN = 8'($urandom);
			@(negedge CLK);
			check({79'h0, POWER_AMP_ENABLE}, {79'h0, k[1] & ~k[0]}, "amp enable");
			check({72'h0, TX_IN_PHASE_OUT}, k[0] ? 80'h0 : {72'h0, TX_IN_PHASE_IN}, "i out");
			check({72'h0, TX_QUADRATURE_OUT}, k[0] ? 80'h0 : {72'h0, TX_QUADRATURE_IN}, "q out");
			rd(5'h10, {6'h00, k[0], 1'h1});
			bus_idle();
		end
		end_test("lock gating");
		give_verdict();
	end
endmodule
